// File: ccau_monitor.sv
`timescale 1ns/1ps
module ccau_monitor (
   input wire        clk_i,
   input wire        rst_b_i,
   input wire [7:0]  s_axi_araddr_i,
   input wire        s_axi_awvalid_i,
   input wire        s_axi_awready_o,
   input wire        s_axi_wvalid_i,
   input wire        s_axi_wready_o,
   input wire        s_axi_bvalid_o,
   input wire        s_axi_bready_i,
   input wire        s_axi_arvalid_i,
   input wire        s_axi_arready_o,
   input wire [31:0] s_axi_rdata_o,
   input wire [1:0]  s_axi_rresp_o,
   input wire        s_axi_rvalid_o,
   input wire        s_axi_rready_i,
   input wire [15:0] cc_req_o,
   input wire        irq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   chk_b_hold: assert property (
      s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o) else $error("bvalid dropped");
   chk_r_hold: assert property (
      s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
      else $error("read answer not held");
   chk_w_refused: assert property (
      s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o) else $error("write not refused");
   chk_ar_refused: assert property (
      s_axi_rvalid_o |-> !s_axi_arready_o) else $error("read not refused");
   chk_w_answer: assert property (
      s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
      |=> !s_axi_bvalid_o ##1 s_axi_bvalid_o) else $error("write answer late");
   chk_r_answer: assert property (
      s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o) else $error("read answer late");
   chk_b_release: assert property (
      s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o && s_axi_awready_o && s_axi_wready_o)
      else $error("write channel not reopened");
   chk_rd_unmapped: assert property (
      s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i[7:2] == 6'h08
      |=> s_axi_rresp_o == 2'h2 && s_axi_rdata_o == 32'h0000_0000) else $error("unmapped read");
   chk_req_pulse: assert property (
      (cc_req_o & $past(cc_req_o)) == 16'h0000) else $error("request longer than one cycle");
   cov_write: cover property (s_axi_bvalid_o && s_axi_bready_i);
   cov_read: cover property (s_axi_rvalid_o && s_axi_rready_i);
   cov_req: cover property (cc_req_o != 16'h0000);
   cov_irq: cover property ($rose(irq_o));
endmodule // ccau_monitor

// File: ccau_pin_model.sv
`timescale 1ns/1ps
module ccau_pin_model (
   input  wire        clk_i,
   input  wire [15:0] lvl_i,
   input  wire [15:0] pin_o_i,
   input  wire [15:0] pin_oe_i,
   output wire [15:0] pin_i_o,
   output reg         ext_o,
   output reg         gen_o
);
   // Device drives where enabled, else the outside level
   assign pin_i_o = (pin_o_i & pin_oe_i) | (lvl_i & ~pin_oe_i);
   initial ext_o = 1'b0;
   initial gen_o = 1'b0;
   // External count edges, slow for the input sync
   task pulse(input integer n);
      repeat (n) begin
         ext_o <= 1'b1;
         repeat (4) @(posedge clk_i);
         ext_o <= 1'b0;
         repeat (4) @(posedge clk_i);
      end
   endtask
   // General timer overflow, one cycle each
   task gen(input integer n);
      repeat (n) begin
         gen_o <= 1'b1;
         @(posedge clk_i);
         gen_o <= 1'b0;
         @(posedge clk_i);
      end
   endtask
endmodule // ccau_pin_model

// File: ccau_regs.vh
`ifndef CCAU_REGS_VH
`define CCAU_REGS_VH
// How it works
// - Sixteen channels, one-cycle resolution, eight cycles when staggered.
// - Two 16-bit time bases, each with its own reload register.
// - Each time base ticks from a selectable power-of-two system clock prescale.
// - Each time base may tick on the general timer overflow pulse instead.
// - An external count pin can step the first time base.
// - Sixteen channel registers, each with its own timer and capture/compare choice.
// - One pin per channel: capture trigger input or compare event output.
// - Compare mode 0: interrupt only, many matches per period.
// - Compare mode 1: pin toggles on every match.
// - Compare mode 2: interrupt only, one match per period.
// - Compare mode 3: pin high on match, low on timer overflow, once per period.
// - Double register: upper channel also toggles the lower channel pin.
// - Single event option stops a compare channel after its first event.
// - Capture latches the assigned timer and raises the channel request.
// - Capture edge is rising, falling or both.
// - Compare channels are checked against their timer on every timer step.
`define CCAU_CTRL_OFS     8'h00
`define CCAU_TB0_VAL_OFS  8'h04
`define CCAU_TB0_RLD_OFS  8'h08
`define CCAU_TB1_VAL_OFS  8'h0C
`define CCAU_TB1_RLD_OFS  8'h10
`define CCAU_STAT_OFS     8'h14
`define CCAU_MASK_OFS     8'h18
`define CCAU_DONE_OFS     8'h1C
`define CCAU_CHVAL_BASE   8'h40
`define CCAU_CHCFG_BASE   8'h80
`define CCAU_CHCFG_END    8'hBC
// Control fields
`define CCAU_CTRL_RUN0    0
`define CCAU_CTRL_RUN1    1
`define CCAU_CTRL_SRC0    3:2
`define CCAU_CTRL_SRC1    5:4
`define CCAU_CTRL_PRE0    9:6
`define CCAU_CTRL_PRE1    13:10
`define CCAU_CTRL_STAG    14
`define CCAU_CTRL_W       15
// Clock sources
`define CCAU_SRC_PRE      2'h0
`define CCAU_SRC_GEN      2'h1
`define CCAU_SRC_EXT      2'h2
// Channel config fields
`define CCAU_CFG_EN       0
`define CCAU_CFG_CMP      1
`define CCAU_CFG_MODE     3:2
`define CCAU_CFG_EDGE     5:4
`define CCAU_CFG_TSEL     6
`define CCAU_CFG_SINGLE   7
`define CCAU_CFG_DBL      8
`define CCAU_CFG_W        9
// Reset values and timing
`define CCAU_CTRL_RST     15'h0000
`define CCAU_CFG_RST      9'h000
`define CCAU_TB_MAX       16'hFFFF
`define CCAU_STAG_LAST    3'h7
`define CCAU_RESP_OKAY    2'h0
`define CCAU_RESP_SLVERR  2'h2
`endif

// File: ccau_tb_top.sv
`timescale 1ns/1ps
module ccau_tb_top;
   reg         clk_i = 1'b0;
   reg         rst_b_i = 1'b0;
   reg  [7:0]  s_axi_awaddr_i = 8'h00;
   reg  [7:0]  s_axi_araddr_i = 8'h00;
   reg  [31:0] s_axi_wdata_i = 32'h0000_0000;
   reg  [3:0]  s_axi_wstrb_i = 4'hF;
   reg         s_axi_awvalid_i = 1'b0;
   reg         s_axi_wvalid_i = 1'b0;
   reg         s_axi_bready_i = 1'b0;
   reg         s_axi_arvalid_i = 1'b0;
   reg         s_axi_rready_i = 1'b0;
   reg  [15:0] lvl = 16'h0000;
   wire        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
   wire        s_axi_arready_o, s_axi_rvalid_o, irq_o;
   wire [1:0]  s_axi_bresp_o, s_axi_rresp_o;
   wire [31:0] s_axi_rdata_o;
   wire [15:0] cc_pin_i, cc_pin_o, cc_pin_oe_o, cc_req_o;
   wire        gen_timer_ovf_i, ext_count_i;
   reg  [1:0]  rsp;
   reg  [31:0] dat;
   reg         p0 = 1'b0;
   integer     failures = 0;
   integer     tests_run = 0;
   integer     ntog = 0;
   integer     k;
   integer     nreq[0:15] = '{default: 0};
   logic [7:0]  chn[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20};
   logic [15:0] cv[6] = '{16'hFFF4, 16'hFFF4, 16'hFFF4, 16'hFFF8, 16'hFFF4, 16'hFFFA};
   logic [8:0]  cf[6] = '{9'h007, 9'h003, 9'h00B, 9'h00F, 9'h087, 9'h107};

   ccau_top uut (.clk_i(clk_i), .rst_b_i(rst_b_i),
      .s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_awvalid_i(s_axi_awvalid_i),
      .s_axi_awready_o(s_axi_awready_o), .s_axi_wdata_i(s_axi_wdata_i),
      .s_axi_wstrb_i(s_axi_wstrb_i), .s_axi_wvalid_i(s_axi_wvalid_i),
      .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
      .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
      .s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
      .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
      .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
      .s_axi_rready_i(s_axi_rready_i), .cc_pin_i(cc_pin_i), .cc_pin_o(cc_pin_o),
      .cc_pin_oe_o(cc_pin_oe_o), .cc_req_o(cc_req_o), .irq_o(irq_o),
      .gen_timer_ovf_i(gen_timer_ovf_i), .ext_count_i(ext_count_i));
   ccau_pin_model pm (.clk_i(clk_i), .lvl_i(lvl), .pin_o_i(cc_pin_o), .pin_oe_i(cc_pin_oe_o),
      .pin_i_o(cc_pin_i), .ext_o(ext_count_i), .gen_o(gen_timer_ovf_i));

   always #4 clk_i = ~clk_i;

   // Request pulses per channel and pin 0 edges
   always @(posedge clk_i) begin
      for (int j = 0; j < 16; j++) if (cc_req_o[j] === 1'b1) nreq[j] <= nreq[j] + 1;
      if (cc_pin_o[0] !== p0) ntog <= ntog + 1;
      p0 <= cc_pin_o[0];
   end

   task end_sim;
      if (failures == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task chk(input [31:0] s, input [31:0] e);
      tests_run++;
      if (s !== e) begin
         failures++;
         $display("BAD %0t seen %h expected %h", $time, s, e);
      end
   endtask

   task wr(input [7:0] a, input [31:0] d);
      s_axi_awaddr_i  <= a;
      s_axi_wdata_i   <= d;
      s_axi_awvalid_i <= 1'b1;
      s_axi_wvalid_i  <= 1'b1;
      s_axi_bready_i  <= 1'b1;
      do begin
         @(posedge clk_i);
         if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
         if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
      end while (s_axi_bvalid_o !== 1'b1);
      rsp = s_axi_bresp_o;
      s_axi_bready_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task rd(input [7:0] a);
      s_axi_araddr_i  <= a;
      s_axi_arvalid_i <= 1'b1;
      s_axi_rready_i  <= 1'b1;
      do begin
         @(posedge clk_i);
         if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
      end while (s_axi_rvalid_o !== 1'b1);
      rsp = s_axi_rresp_o;
      dat = s_axi_rdata_o;
      s_axi_rready_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task wait_req(input integer c, input integer n);
      for (int i = 0; i < 400 && nreq[c] < n; i++) @(posedge clk_i);
   endtask

   initial begin
      repeat (10) @(posedge clk_i);
      rst_b_i <= 1'b1;
      @(posedge clk_i);
      rd(8'h00);
      chk(dat, 32'h0000_0000);
      wr(8'h08, 32'h0000_FFF0);
      rd(8'h08);
      chk(dat, 32'h0000_FFF0);
      wr(8'hFC, 32'h0000_0001);
      chk(rsp, 32'h0000_0002);
      rd(8'h20);
      chk({rsp, dat[29:0]}, 32'h8000_0000);
      wr(8'h04, 32'h0000_FFF0);
      for (k = 0; k < 6; k++) begin
         wr(8'h40 + chn[k], {16'h0000, cv[k]});
         wr(8'h80 + chn[k], {23'h00_0000, cf[k]});
      end
      wr(8'h00, 32'h0000_0001);
      wait_req(8, 4);
      repeat (3) @(posedge clk_i);
      chk(nreq[0], 4);
      chk(ntog, 8);
      chk(cc_pin_o[0], 1'b0);
      chk(nreq[1], 4);
      chk(nreq[2], 4);
      chk(cc_pin_o[2:1], 2'h0);
      chk(nreq[3], 4);
      chk(cc_pin_o[3], 1'b1);
      chk(nreq[4], 1);
      chk(nreq[8], 4);
      chk(cc_pin_oe_o, 32'h0000_001F);
      repeat (4) @(posedge clk_i);
      chk(cc_pin_o[3], 1'b0);
      rd(8'h1C);
      chk(dat, 32'h0000_0010);
      wr(8'h00, 32'h0000_0000);
      wr(8'h0C, 32'h0000_1234);
      wr(8'h18, 32'h0000_0020);
      wr(8'h94, 32'h0000_0051);
      lvl[5] <= 1'b1;
      wait_req(5, 1);
      rd(8'h54);
      chk(dat, 32'h0000_1234);
      chk(irq_o, 1'b1);
      lvl[5] <= 1'b0;
      repeat (8) @(posedge clk_i);
      chk(nreq[5], 1);
      wr(8'h14, 32'h0000_0020);
      repeat (2) @(posedge clk_i);
      chk(irq_o, 1'b0);
      wr(8'h00, 32'h0000_0012);
      pm.gen(5);
      wr(8'h00, 32'h0000_0000);
      rd(8'h0C);
      chk(dat, 32'h0000_1239);
      wr(8'h00, 32'h0000_0C02);
      repeat (80) @(posedge clk_i);
      wr(8'h00, 32'h0000_0000);
      rd(8'h0C);
      chk((dat - 32'h0000_1239) >> 1, 32'h0000_0005);
      wr(8'h04, 32'h0000_0100);
      wr(8'h00, 32'h0000_0009);
      pm.pulse(3);
      rd(8'h04);
      chk(dat, 32'h0000_0103);
      wr(8'h0C, 32'h0000_0000);
      wr(8'h00, 32'h0000_4002);
      repeat (80) @(posedge clk_i);
      wr(8'h00, 32'h0000_0000);
      rd(8'h0C);
      chk(dat >> 1, 32'h0000_0005);
      end_sim;
   end

   initial begin
      repeat (20000) @(posedge clk_i);
      failures++;
      end_sim;
   end
endmodule // ccau_tb_top

bind ccau_top ccau_monitor mon (.clk_i(clk_i), .rst_b_i(rst_b_i),
   .s_axi_araddr_i(s_axi_araddr_i), .s_axi_awvalid_i(s_axi_awvalid_i),
   .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
   .s_axi_wready_o(s_axi_wready_o), .s_axi_bvalid_o(s_axi_bvalid_o),
   .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i),
   .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
   .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
   .s_axi_rready_i(s_axi_rready_i), .cc_req_o(cc_req_o), .irq_o(irq_o));

// File: ccau_top.v
// The implementer's own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "ccau_regs.vh"
module ccau_top (
   input  wire        clk_i,
   input  wire        rst_b_i,
   input  wire [7:0]  s_axi_awaddr_i,
   input  wire        s_axi_awvalid_i,
   output reg         s_axi_awready_o,
   input  wire [31:0] s_axi_wdata_i,
   input  wire [3:0]  s_axi_wstrb_i,
   input  wire        s_axi_wvalid_i,
   output reg         s_axi_wready_o,
   output reg  [1:0]  s_axi_bresp_o,
   output reg         s_axi_bvalid_o,
   input  wire        s_axi_bready_i,
   input  wire [7:0]  s_axi_araddr_i,
   input  wire        s_axi_arvalid_i,
   output reg         s_axi_arready_o,
   output reg  [31:0] s_axi_rdata_o,
   output reg  [1:0]  s_axi_rresp_o,
   output reg         s_axi_rvalid_o,
   input  wire        s_axi_rready_i,
   input  wire [15:0] cc_pin_i,
   output reg  [15:0] cc_pin_o,
   output reg  [15:0] cc_pin_oe_o,
   output reg  [15:0] cc_req_o,
   output reg         irq_o,
   input  wire        gen_timer_ovf_i,
   input  wire        ext_count_i
);

   // Merge byte strobes into a 32-bit word
   function [31:0] strb_merge;
      input [31:0] old_v;
      input [31:0] new_v;
      input [3:0]  strb;
      integer      b;
      begin
         strb_merge = old_v;
         for (b = 0; b < 4; b = b + 1) begin
            if (strb[b]) begin
               strb_merge[b*8 +: 8] = new_v[b*8 +: 8];
            end
         end
      end
   endfunction

   // Prescaler tick for a divide by two to the power pre
   function pre_tick;
      input [3:0]  pre;
      input [15:0] cnt;
      reg   [15:0] msk;
      begin
         msk      = (16'h0001 << pre) - 16'h0001;
         pre_tick = ((cnt & msk) == msk);
      end
   endfunction

   // Address map check
   function addr_ok;
      input [7:0] a;
      begin
         addr_ok = (a <= `CCAU_DONE_OFS) ||
                   ((a >= `CCAU_CHVAL_BASE) && (a <= `CCAU_CHCFG_END));
      end
   endfunction

   reg [`CCAU_CTRL_W-1:0] ctrl_reg;
   reg [15:0]             tb_val_reg [0:1];
   reg [15:0]             tb_rld_reg [0:1];
   reg [15:0]             ch_val_reg [0:15];
   reg [`CCAU_CFG_W-1:0]  ch_cfg_reg [0:15];
   reg [17:0]             stat_reg;
   reg [17:0]             mask_reg;
   reg [15:0]             done_reg;
   reg [15:0]             hit_reg;
   reg [15:0]             pre_cnt_reg;
   reg [2:0]              slot_reg;
   reg [1:0]              tb_upd_reg;
   reg [1:0]              tb_ovf_reg;
   reg [15:0]             pin_s1_reg;
   reg [15:0]             pin_s2_reg;
   reg [15:0]             pin_s3_reg;
   reg [2:0]              ext_s_reg;
   reg                    aw_got_reg;
   reg                    w_got_reg;
   reg [7:0]              awaddr_reg;
   reg [31:0]             wdata_reg;
   reg [3:0]              wstrb_reg;

   reg [1:0]              tick;
   reg [15:0]             cap_ev;
   reg [15:0]             cmp_ev;
   reg [15:0]             tog_m;
   reg [15:0]             set_m;
   reg [15:0]             clr_m;
   reg [15:0]             oe_next;
   reg [31:0]             rd_next;
   reg [15:0]             pin_next;
   reg [17:0]             stat_next;
   integer                i;
   integer                t;
   integer                p;
   // Loop indices of the clocked process
   integer                ci;
   integer                ct;

   wire       wr_go   = aw_got_reg & w_got_reg & ~s_axi_bvalid_o;
   wire       wr_ok   = wr_go & addr_ok(awaddr_reg);
   wire [3:0] wr_idx  = awaddr_reg[5:2];
   wire       ext_rise = ext_s_reg[1] & ~ext_s_reg[2];
   wire       stag_ok = ~ctrl_reg[`CCAU_CTRL_STAG] | (slot_reg == `CCAU_STAG_LAST);
   wire [15:0] pin_rise = pin_s2_reg & ~pin_s3_reg;
   wire [15:0] pin_fall = ~pin_s2_reg & pin_s3_reg;
   wire [31:0] wr_data  = strb_merge(32'h0000_0000, wdata_reg, wstrb_reg);

   // Time base step enables
   always @* begin
      tick[0] = 1'b0;
      tick[1] = 1'b0;
      for (t = 0; t < 2; t = t + 1) begin
         case (t == 0 ? ctrl_reg[`CCAU_CTRL_SRC0] : ctrl_reg[`CCAU_CTRL_SRC1])
            `CCAU_SRC_PRE: tick[t] = pre_tick(t == 0 ? ctrl_reg[`CCAU_CTRL_PRE0] :
                                              ctrl_reg[`CCAU_CTRL_PRE1],
                                              pre_cnt_reg);
            `CCAU_SRC_GEN: tick[t] = gen_timer_ovf_i;
            `CCAU_SRC_EXT: tick[t] = (t == 0) & ext_rise;
            default:       tick[t] = 1'b0;
         endcase
         tick[t] = tick[t] & ctrl_reg[t] & stag_ok;
      end
   end

   // Channel events and pin actions
   always @* begin
      cap_ev  = 16'h0000;
      cmp_ev  = 16'h0000;
      tog_m   = 16'h0000;
      set_m   = 16'h0000;
      clr_m   = 16'h0000;
      oe_next = 16'h0000;
      for (i = 0; i < 16; i = i + 1) begin
         p = ((i >= 8) && ch_cfg_reg[i][`CCAU_CFG_DBL]) ? i - 8 : i;
         if (ch_cfg_reg[i][`CCAU_CFG_EN] && !ch_cfg_reg[i][`CCAU_CFG_CMP]) begin
            cap_ev[i] = (ch_cfg_reg[i][4] & pin_rise[i]) |
                        (ch_cfg_reg[i][5] & pin_fall[i]);
         end
         if (ch_cfg_reg[i][`CCAU_CFG_EN] && ch_cfg_reg[i][`CCAU_CFG_CMP]) begin
            oe_next[p] = 1'b1;
            cmp_ev[i]  = tb_upd_reg[ch_cfg_reg[i][`CCAU_CFG_TSEL]] &
                         (tb_val_reg[ch_cfg_reg[i][`CCAU_CFG_TSEL]] ==
                          ch_val_reg[i]) &
                         ~done_reg[i] &
                         ~(ch_cfg_reg[i][3] & hit_reg[i]);
            case (ch_cfg_reg[i][`CCAU_CFG_MODE])
               2'h1: tog_m[p] = tog_m[p] ^ cmp_ev[i];
               2'h3: begin
                  set_m[p] = set_m[p] | cmp_ev[i];
                  clr_m[p] = clr_m[p] |
                             tb_ovf_reg[ch_cfg_reg[i][`CCAU_CFG_TSEL]];
               end
               default: ;
            endcase
            if (p != i && ch_cfg_reg[i][`CCAU_CFG_MODE] != 2'h1) begin
               tog_m[p] = tog_m[p] ^ cmp_ev[i];
            end
         end
      end
      pin_next = ((cc_pin_o ^ tog_m) & ~clr_m) | set_m;
      stat_next = {tb_ovf_reg, cap_ev | cmp_ev} | stat_reg;
      if (wr_ok && awaddr_reg == `CCAU_STAT_OFS) begin
         stat_next = {tb_ovf_reg, cap_ev | cmp_ev} |
                     (stat_reg & ~wr_data[17:0]);
      end
   end

   // Read data selection
   always @* begin
      rd_next = 32'h0000_0000;
      if (s_axi_araddr_i >= `CCAU_CHCFG_BASE) begin
         rd_next[`CCAU_CFG_W-1:0] = ch_cfg_reg[s_axi_araddr_i[5:2]];
      end else if (s_axi_araddr_i >= `CCAU_CHVAL_BASE) begin
         rd_next[15:0] = ch_val_reg[s_axi_araddr_i[5:2]];
      end else begin
         case (s_axi_araddr_i)
            `CCAU_CTRL_OFS:    rd_next[`CCAU_CTRL_W-1:0] = ctrl_reg;
            `CCAU_TB0_VAL_OFS: rd_next[15:0] = tb_val_reg[0];
            `CCAU_TB0_RLD_OFS: rd_next[15:0] = tb_rld_reg[0];
            `CCAU_TB1_VAL_OFS: rd_next[15:0] = tb_val_reg[1];
            `CCAU_TB1_RLD_OFS: rd_next[15:0] = tb_rld_reg[1];
            `CCAU_STAT_OFS:    rd_next[17:0] = stat_reg;
            `CCAU_MASK_OFS:    rd_next[17:0] = mask_reg;
            `CCAU_DONE_OFS:    rd_next[15:0] = done_reg;
            default:           rd_next = 32'h0000_0000;
         endcase
      end
      if (!addr_ok(s_axi_araddr_i)) begin
         rd_next = 32'h0000_0000;
      end
   end

   // Bus handshakes
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_axi_awready_o <= 1'b1;
         s_axi_wready_o  <= 1'b1;
         s_axi_bvalid_o  <= 1'b0;
         s_axi_bresp_o   <= `CCAU_RESP_OKAY;
         s_axi_arready_o <= 1'b1;
         s_axi_rvalid_o  <= 1'b0;
         s_axi_rdata_o   <= 32'h0000_0000;
         s_axi_rresp_o   <= `CCAU_RESP_OKAY;
         aw_got_reg      <= 1'b0;
         w_got_reg       <= 1'b0;
         awaddr_reg      <= 8'h00;
         wdata_reg       <= 32'h0000_0000;
         wstrb_reg       <= 4'h0;
      end else begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            awaddr_reg      <= {s_axi_awaddr_i[7:2], 2'b00};
            aw_got_reg      <= 1'b1;
            s_axi_awready_o <= 1'b0;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            wdata_reg      <= s_axi_wdata_i;
            wstrb_reg      <= s_axi_wstrb_i;
            w_got_reg      <= 1'b1;
            s_axi_wready_o <= 1'b0;
         end
         if (wr_go) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= wr_ok ? `CCAU_RESP_OKAY : `CCAU_RESP_SLVERR;
            aw_got_reg     <= 1'b0;
            w_got_reg      <= 1'b0;
         end
         if (s_axi_bvalid_o && s_axi_bready_i) begin
            s_axi_bvalid_o  <= 1'b0;
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o  <= 1'b1;
         end
         if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b1;
            s_axi_rdata_o   <= rd_next;
            s_axi_rresp_o   <= addr_ok(s_axi_araddr_i) ? `CCAU_RESP_OKAY :
                                                         `CCAU_RESP_SLVERR;
         end
         if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o  <= 1'b0;
            s_axi_arready_o <= 1'b1;
         end
      end
   end

   // Time bases, channels and interrupt state
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl_reg    <= `CCAU_CTRL_RST;
         stat_reg    <= 18'h0_0000;
         mask_reg    <= 18'h0_0000;
         done_reg    <= 16'h0000;
         hit_reg     <= 16'h0000;
         pre_cnt_reg <= 16'h0000;
         slot_reg    <= 3'h0;
         tb_upd_reg  <= 2'h0;
         tb_ovf_reg  <= 2'h0;
         pin_s1_reg  <= 16'h0000;
         pin_s2_reg  <= 16'h0000;
         pin_s3_reg  <= 16'h0000;
         ext_s_reg   <= 3'h0;
         cc_pin_o    <= 16'h0000;
         cc_pin_oe_o <= 16'h0000;
         cc_req_o    <= 16'h0000;
         irq_o       <= 1'b0;
         for (ct = 0; ct < 2; ct = ct + 1) begin
            tb_val_reg[ct] <= 16'h0000;
            tb_rld_reg[ct] <= 16'h0000;
         end
         for (ci = 0; ci < 16; ci = ci + 1) begin
            ch_val_reg[ci] <= 16'h0000;
            ch_cfg_reg[ci] <= `CCAU_CFG_RST;
         end
      end else begin
         pin_s1_reg  <= cc_pin_i;
         pin_s2_reg  <= pin_s1_reg;
         pin_s3_reg  <= pin_s2_reg;
         ext_s_reg   <= {ext_s_reg[1:0], ext_count_i};
         pre_cnt_reg <= pre_cnt_reg + 16'h0001;
         slot_reg    <= slot_reg + 3'h1;
         tb_upd_reg  <= tick;
         for (ct = 0; ct < 2; ct = ct + 1) begin
            tb_ovf_reg[ct] <= tick[ct] & (tb_val_reg[ct] == `CCAU_TB_MAX);
            if (tick[ct]) begin
               tb_val_reg[ct] <= (tb_val_reg[ct] == `CCAU_TB_MAX) ? tb_rld_reg[ct] :
                                 tb_val_reg[ct] + 16'h0001;
            end
         end
         // Register writes
         if (wr_ok) begin
            case (awaddr_reg)
               `CCAU_CTRL_OFS:    ctrl_reg <= wr_data[`CCAU_CTRL_W-1:0];
               `CCAU_TB0_VAL_OFS: tb_val_reg[0] <= wr_data[15:0];
               `CCAU_TB0_RLD_OFS: tb_rld_reg[0] <= wr_data[15:0];
               `CCAU_TB1_VAL_OFS: tb_val_reg[1] <= wr_data[15:0];
               `CCAU_TB1_RLD_OFS: tb_rld_reg[1] <= wr_data[15:0];
               `CCAU_MASK_OFS:    mask_reg <= wr_data[17:0];
               default: ;
            endcase
         end
         // Per-channel capture, compare and single-event state
         for (ci = 0; ci < 16; ci = ci + 1) begin
            if (wr_ok && awaddr_reg == (`CCAU_CHVAL_BASE | {2'b00, wr_idx, 2'b00})) begin
               ch_val_reg[ci] <= (wr_idx == ci) ? wr_data[15:0] : ch_val_reg[ci];
            end
            if (cap_ev[ci]) begin
               ch_val_reg[ci] <= tb_val_reg[ch_cfg_reg[ci][`CCAU_CFG_TSEL]];
            end
            if (tb_ovf_reg[ch_cfg_reg[ci][`CCAU_CFG_TSEL]]) begin
               hit_reg[ci] <= 1'b0;
            end
            if (cmp_ev[ci]) begin
               hit_reg[ci] <= 1'b1;
            end
            if (wr_ok && wr_idx == ci &&
                awaddr_reg == (`CCAU_CHCFG_BASE | {2'b00, wr_idx, 2'b00})) begin
               ch_cfg_reg[ci] <= wr_data[`CCAU_CFG_W-1:0];
               done_reg[ci]   <= 1'b0;
               hit_reg[ci]    <= 1'b0;
            end else if (cmp_ev[ci] && ch_cfg_reg[ci][`CCAU_CFG_SINGLE]) begin
               done_reg[ci] <= 1'b1;
            end
         end
         cc_pin_o    <= pin_next;
         cc_pin_oe_o <= oe_next;
         cc_req_o    <= cap_ev | cmp_ev;
         stat_reg    <= stat_next;
         irq_o       <= |(stat_next & mask_reg);
      end
   end

endmodule // ccau_top
